//--- verification/serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
  input  wire logic ref_clk,
  input  wire logic sync_clk_out,
  output logic      line,
  output logic      slave_clk
);
  initial line = 1'b1;
  initial slave_clk = 1'b0;

  // In slave mode this side owns the clock; data leads each rising edge by half a period.
  task automatic send_slave(input logic [8:0] c, input int n, input int hp);
    for (int i = 0; i < n; i++) begin
      line <= c[i];
      repeat (hp) @(posedge ref_clk);
      slave_clk <= 1'b1;
      repeat (hp) @(posedge ref_clk);
      slave_clk <= 1'b0;
    end
  endtask

  // A low stop bit is sent only when the caller asks for a framing fault.
  task automatic send_async(input logic [8:0] c, input int n, input logic stop, input int bt);
    line <= 1'b0;
    repeat (bt) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      line <= c[i];
      repeat (bt) @(posedge ref_clk);
    end
    line <= stop;
    repeat (bt) @(posedge ref_clk);
    line <= 1'b1;
  endtask

  // Data moves on the falling clock so it is steady when the master samples.
  task automatic send_sync(input logic [8:0] c, input int n);
    line <= c[0];
    for (int i = 1; i < n; i++) begin
      @(negedge sync_clk_out);
      line <= c[i];
    end
    @(negedge sync_clk_out);
    line <= ~c[n-1];
  endtask
endmodule

//--- verification/serial_rx_checker.sv
`timescale 1ns/100ps
module serial_rx_checker (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sync_clk_oe_n,
  input wire logic        irq
);
  logic cont_off;
  logic mask_zero;
  logic master_on;
  wire  wr_ok = psel && penable && pready && pwrite && !pslverr;
  wire  rd_st = pready && !pwrite && paddr == 12'h000;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cont_off  <= 1'b1;
      mask_zero <= 1'b1;
      master_on <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == 12'h000) cont_off <= !pwdata[4];
      if (paddr == 12'h014) mask_zero <= pwdata[2:0] == 3'h0;
      if (paddr == 12'h008) master_on <= pwdata[1:0] == 2'h3;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_ready_after_setup;
    s_setup |=> s_access;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  property p_err_data_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  property p_err_unmapped;
    pready && paddr > 12'h014 |-> pslverr;
  endproperty
  property p_bit3_zero;
    rd_st |-> prdata[31:7] == 25'h0 && !prdata[3];
  endproperty
  property p_overrun_clear;
    rd_st && cont_off |-> !prdata[1];
  endproperty
  property p_irq_masked;
    mask_zero && $past(mask_zero) |-> !irq;
  endproperty
  property p_oe_released;
    !master_on && $past(!master_on) |-> sync_clk_oe_n;
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no access answer");
  a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");
  a_err_data_zero: assert property (p_err_data_zero) else $error("error read not zero");
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped accepted");
  a_bit3_zero: assert property (p_bit3_zero) else $error("empty bits nonzero");
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept");
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");
  a_oe_released: assert property (p_oe_released) else $error("clock driven");
endmodule

bind serial_receive_control_status serial_rx_checker chk (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sync_clk_oe_n(sync_clk_oe_n), .irq(irq)
);

//--- verification/test_serial_receive_control_status.sv
`timescale 1ns/100ps
module test_serial_receive_control_status;
  logic        ref_clk, nrst, psel, penable, pwrite, sync_clk_in, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, m_ctl;
  logic        pready, pslverr, rx_data_in, sync_clk_out, sync_clk_oe_n, irq;
  int          bad_count, compares, cyc, m_full, m_framing_error_flag, m_overrun_error_flag, m_data, c;

  serial_receive_control_status dut (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data_in(rx_data_in), .sync_clk_in(sync_clk_in),
    .sync_clk_out(sync_clk_out), .sync_clk_oe_n(sync_clk_oe_n), .irq(irq));
  serial_peer peer (.ref_clk(ref_clk), .sync_clk_out(sync_clk_out), .line(rx_data_in),
    .slave_clk(sync_clk_in));

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic m_char(input int d, input int ok);
    if (m_full != 0) m_overrun_error_flag = 1;
    else begin
      m_full = 1;
      m_data = d;
      m_framing_error_flag = !ok;
    end
  endtask

  // The short settle wait covers the input synchroniser after the stop bit.
  task automatic rx(input int d, input int n, input logic ok);
    peer.send_async(9'(d), n, ok, 11);
    repeat (6) @(posedge ref_clk);
    if (m_ctl[4]) m_char(d, ok);
  endtask

  // Slave mode: the peer clocks eight bits, then the synchroniser is given time to settle.
  task automatic rxs(input int d);
    peer.send_slave(9'(d), 8, 4);
    repeat (6) @(posedge ref_clk);
    if (m_ctl[4]) m_char(d, 1);
  endtask

  task automatic st();
    apb(1'b0, 12'h000, 32'h0);
    chk("status", m_ctl | 32'(m_framing_error_flag << 2) | 32'(m_overrun_error_flag << 1) | 32'((m_data >> 8) & 1), rdv);
  endtask

  task automatic rd_data();
    apb(1'b0, 12'h004, 32'h0);
    chk("rx data", 32'(m_data), rdv);
    m_full = 0;
    m_framing_error_flag = 0;
  endtask

  task automatic irq_chk(input logic v);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'(v), 32'(irq));
  endtask

  initial begin
    ref_clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; m_ctl = 32'h0;
    c = $urandom(64840);
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    st();
    chk("clock enable", 32'h1, 32'(sync_clk_oe_n));
    apb(1'b0, 12'h00c, 32'h0); chk("baud", 32'h0000000a, rdv);
    apb(1'b0, 12'h014, 32'h0); chk("mask", 32'h0, rdv);
    apb(1'b1, 12'h018, 32'hffffffff); chk("slverr", 32'h1, 32'(errv));
    apb(1'b0, 12'h018, 32'h0); chk("unmapped", 32'h0, rdv);
    apb(1'b1, 12'h014, 32'h1);
    m_ctl = 32'h70; apb(1'b1, 12'h000, m_ctl);
    c = $urandom % 512; rx(c, 9, 1'b1);
    irq_chk(1'b1);
    st();
    rd_data();
    apb(1'b1, 12'h010, 32'h7); irq_chk(1'b0);
    rx($urandom % 512, 9, 1'b0); st();
    rd_data();
    rx($urandom % 512, 9, 1'b1); st();
    rd_data();
    rx($urandom % 512, 9, 1'b1); rx($urandom % 512, 9, 1'b1); st();
    m_ctl = 32'h40; apb(1'b1, 12'h000, m_ctl); m_overrun_error_flag = 0; st();
    rd_data();
    apb(1'b1, 12'h010, 32'h7);
    m_ctl = 32'h20; apb(1'b1, 12'h000, m_ctl); rx($urandom % 256, 8, 1'b1);
    apb(1'b0, 12'h010, 32'h0); chk("irq status", 32'h0, rdv);
    apb(1'b1, 12'h014, 32'h0);
    m_ctl = 32'h10; apb(1'b1, 12'h000, m_ctl); rx($urandom % 256, 8, 1'b1);
    apb(1'b0, 12'h010, 32'h0); chk("irq status", 32'h1, rdv);
    irq_chk(1'b0);
    rd_data();
    m_ctl = 32'h0; apb(1'b1, 12'h000, m_ctl);
    apb(1'b1, 12'h008, 32'h3);
    c = $urandom % 256;
    fork
      peer.send_sync(9'(c), 8);
    join_none
    m_ctl = 32'h20; apb(1'b1, 12'h000, m_ctl);
    chk("clock enable", 32'h0, 32'(sync_clk_oe_n));
    rdv = 32'h20;
    for (int i = 0; i < 100 && rdv[5]; i++) apb(1'b0, 12'h000, 32'h0);
    chk("single", 32'h0, rdv & 32'h20);
    chk("clock idle", 32'h0, 32'(sync_clk_out));
    m_char(c, 1);
    rd_data();
    apb(1'b1, 12'h010, 32'h7);
    c = $urandom % 256;
    fork
      peer.send_sync(9'(c), 8);
    join_none
    m_ctl = 32'h30; apb(1'b1, 12'h000, m_ctl);
    rdv = 32'h0;
    for (int i = 0; i < 100 && !rdv[0]; i++) apb(1'b0, 12'h010, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("precedence", 32'h30, rdv & 32'h30);
    m_ctl = 32'h0; apb(1'b1, 12'h000, m_ctl);
    m_char(c, 1);
    rd_data();
    apb(1'b1, 12'h008, 32'h1);
    m_ctl = 32'h20; apb(1'b1, 12'h000, m_ctl);
    chk("clock enable", 32'h1, 32'(sync_clk_oe_n));
    apb(1'b1, 12'h010, 32'h7);
    rxs($urandom % 256);
    apb(1'b0, 12'h010, 32'h0); chk("irq status", 32'h0, rdv);
    st();
    m_ctl = 32'h10; apb(1'b1, 12'h000, m_ctl);
    rxs($urandom % 256);
    rd_data();
    rxs($urandom % 256);
    st();
    rd_data();
    end_of_test();
  end
endmodule

//--- verilog/serial_receive_control_status.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "serial_rx_cfg.svh"

module serial_receive_control_status #(
  parameter int DIV_W = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_data_in,
  input  wire logic        sync_clk_in,
  output logic             sync_clk_out,
  output logic             sync_clk_oe_n,
  output logic             irq
);

  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div_w
    $error("DIV_W out of range");
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  serial_rx_pkg::rx_ctrl_t  ctrl_reg;
  serial_rx_pkg::rx_mode_t  mode_reg;
  serial_rx_pkg::rx_state_t state_reg;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic [2:0]       irq_stat_reg;
  logic [2:0]       irq_mask_reg;
  logic [8:0]       data_reg;
  logic             full_reg;
  logic [8:0]       shift_reg;
  logic [3:0]       bit_reg;
  logic [2:0]       rx_sync_reg;
  logic [2:0]       ck_sync_reg;
  logic             rx_filt_reg;
  logic             ck_filt_reg;
  logic             ck_prev_reg;
  logic             sclk_reg;
  localparam logic [7:0] CTRL_RST = `RST_STATUS_CONTROL;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Only stages 2 and 3 are compared, so a metastable first stage never leaks.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_sync_reg <= 3'h7;
      ck_sync_reg <= 3'h0;
      rx_filt_reg <= 1'b1;
      ck_filt_reg <= 1'b0;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_data_in};
      ck_sync_reg <= {ck_sync_reg[1:0], sync_clk_in};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_filt_reg <= rx_sync_reg[2];
      end
      if (ck_sync_reg[1] == ck_sync_reg[2]) begin
        ck_filt_reg <= ck_sync_reg[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Reception enable and sampling ticks
  // --------------------------------------------------------------------------
  logic run_en;
  logic single_act;
  logic tick;
  logic half_tick;
  logic ck_rise;
  // Single-receive only matters for a synchronous master; continuous wins.
  assign single_act = ctrl_reg.single_en && mode_reg.sync && mode_reg.master
                      && !ctrl_reg.cont_en;
  assign run_en     = ctrl_reg.cont_en || single_act;
  assign ck_rise    = ck_filt_reg && !ck_prev_reg;
  assign tick       = (cnt_reg == div_reg);
  assign half_tick  = (cnt_reg == (div_reg >> 1));

  logic bit_take;
  always_comb begin
    if (!mode_reg.sync) begin
      bit_take = tick;
    end else if (mode_reg.master) begin
      bit_take = tick && sclk_reg;
    end else begin
      bit_take = ck_rise;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_reg     <= '0;
      ck_prev_reg <= 1'b0;
      sclk_reg    <= 1'b0;
    end else begin
      ck_prev_reg <= ck_filt_reg;
      if (state_reg == serial_rx_pkg::ST_IDLE && !mode_reg.sync) begin
        cnt_reg <= '0;
      end else if (state_reg == serial_rx_pkg::ST_START && half_tick) begin
        cnt_reg <= '0; // Restarting mid start bit puts every later tick mid-bit.
      end else if (tick) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      if (mode_reg.sync && mode_reg.master && run_en && tick) begin
        sclk_reg <= !sclk_reg;
      end else if (!(mode_reg.sync && mode_reg.master && run_en)) begin
        sclk_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive engine
  // --------------------------------------------------------------------------
  logic [3:0] nbits;
  logic       char_done;
  logic       stop_ok;
  assign nbits = ctrl_reg.nine_sel ? 4'd9 : 4'd8;
  assign stop_ok = rx_filt_reg;
  assign char_done = mode_reg.sync
                     ? (state_reg == serial_rx_pkg::ST_DATA && bit_take && bit_reg == nbits - 1'b1)
                     : (state_reg == serial_rx_pkg::ST_STOP && tick);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg <= serial_rx_pkg::ST_IDLE;
      shift_reg <= '0;
      bit_reg   <= '0;
    end else if (!run_en) begin
      state_reg <= serial_rx_pkg::ST_IDLE;
      bit_reg   <= '0;
    end else begin
      case (state_reg)
        serial_rx_pkg::ST_IDLE: begin
          bit_reg <= '0;
          if (mode_reg.sync) begin
            state_reg <= serial_rx_pkg::ST_DATA;
          end else if (!rx_filt_reg) begin
            state_reg <= serial_rx_pkg::ST_START;
          end
        end
        serial_rx_pkg::ST_START: begin
          if (half_tick) begin
            state_reg <= rx_filt_reg ? serial_rx_pkg::ST_IDLE : serial_rx_pkg::ST_DATA;
          end
        end
        serial_rx_pkg::ST_DATA: begin
          if (bit_take) begin
            shift_reg[bit_reg] <= rx_filt_reg;
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == nbits - 1'b1) begin
              bit_reg   <= '0;
              state_reg <= mode_reg.sync ? serial_rx_pkg::ST_DATA : serial_rx_pkg::ST_STOP;
            end
          end
        end
        serial_rx_pkg::ST_STOP: begin
          if (tick) begin
            state_reg <= serial_rx_pkg::ST_IDLE;
          end
        end
        default: state_reg <= serial_rx_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Receive storage and status flags
  // --------------------------------------------------------------------------
  logic data_rd;
  logic [8:0] char_val;
  assign data_rd  = rd_acc && hit(paddr, `ADDR_RX_DATA);
  // A synchronous character completes on its last sample, so that bit comes from the pin.
  assign char_val = !mode_reg.sync     ? {shift_reg[8] & ctrl_reg.nine_sel, shift_reg[7:0]}
                    : ctrl_reg.nine_sel ? {rx_filt_reg, shift_reg[7:0]}
                    : {1'b0, rx_filt_reg, shift_reg[6:0]};

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      data_reg <= '0;
      full_reg <= 1'b0;
    end else if (char_done && !full_reg) begin
      data_reg <= char_val;
      full_reg <= 1'b1;
    end else if (data_rd) begin
      full_reg <= 1'b0;
    end
  end

  // Storage is one character deep, so an overrun drops the newcomer.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_reg <= {CTRL_RST[`BIT_NINE_SEL:`BIT_CONT_EN], CTRL_RST[`BIT_FRAME_ERR:`BIT_NINTH]};
    end else begin
      if (wr_acc && hit(paddr, `ADDR_RX_STATUS_CONTROL)) begin
        ctrl_reg.nine_sel  <= pwdata[`BIT_NINE_SEL];
        ctrl_reg.single_en <= pwdata[`BIT_SINGLE_EN];
        ctrl_reg.cont_en   <= pwdata[`BIT_CONT_EN];
        if (!pwdata[`BIT_CONT_EN]) begin
          ctrl_reg.overrun <= 1'b0;
        end
      end
      if (single_act && char_done) begin
        ctrl_reg.single_en <= 1'b0;
      end
      if (char_done && !full_reg) begin
        ctrl_reg.frame_err <= mode_reg.sync ? 1'b0 : !stop_ok;
        ctrl_reg.ninth     <= char_val[8];
      end else if (data_rd && !mode_reg.sync) begin
        ctrl_reg.frame_err <= 1'b0;
      end
      if (char_done && full_reg) begin
        ctrl_reg.overrun <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration, interrupts and bus response
  // --------------------------------------------------------------------------
  logic [2:0] irq_evt;
  assign irq_evt = {char_done && full_reg,
                    char_done && !full_reg && !mode_reg.sync && !stop_ok,
                    char_done && !full_reg};

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_reg     <= '0;
      div_reg      <= DIV_W'(`RST_BAUD_DIV);
      irq_mask_reg <= `RST_IRQ_MASK;
      irq_stat_reg <= '0;
    end else begin
      if (wr_acc && hit(paddr, `ADDR_MODE)) begin
        mode_reg.sync   <= pwdata[`BIT_MODE_SYNC];
        mode_reg.master <= pwdata[`BIT_MODE_MASTER];
      end
      if (wr_acc && hit(paddr, `ADDR_BAUD_DIV)) begin
        div_reg <= (pwdata[DIV_W-1:0] < 2) ? DIV_W'(2) : pwdata[DIV_W-1:0];
      end
      if (wr_acc && hit(paddr, `ADDR_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[2:0];
      end
      // A new event wins over a clear in the same cycle.
      if (wr_acc && hit(paddr, `ADDR_IRQ_STATUS)) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_evt;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_evt;
      end
    end
  end

  logic [31:0] rd_mux;
  logic        bad_addr;
  always_comb begin
    rd_mux   = '0;
    bad_addr = 1'b0;
    if (hit(paddr, `ADDR_RX_STATUS_CONTROL)) begin
      rd_mux[`BIT_NINE_SEL]  = ctrl_reg.nine_sel;
      rd_mux[`BIT_SINGLE_EN] = ctrl_reg.single_en;
      rd_mux[`BIT_CONT_EN]   = ctrl_reg.cont_en;
      rd_mux[`BIT_FRAME_ERR] = ctrl_reg.frame_err;
      rd_mux[`BIT_OVERRUN]   = ctrl_reg.overrun;
      rd_mux[`BIT_NINTH]     = ctrl_reg.ninth; // bit 3 stays 0
    end else if (hit(paddr, `ADDR_RX_DATA)) begin
      rd_mux[8:0] = data_reg;
    end else if (hit(paddr, `ADDR_MODE)) begin
      rd_mux[1:0] = {mode_reg.master, mode_reg.sync};
    end else if (hit(paddr, `ADDR_BAUD_DIV)) begin
      rd_mux[DIV_W-1:0] = div_reg;
    end else if (hit(paddr, `ADDR_IRQ_STATUS)) begin
      rd_mux[2:0] = irq_stat_reg;
    end else if (hit(paddr, `ADDR_IRQ_MASK)) begin
      rd_mux[2:0] = irq_mask_reg;
    end else begin
      bad_addr = 1'b1;
    end
  end

  // Zero-wait slave: pready is registered high in the access cycle itself.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata        <= '0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      irq           <= 1'b0;
      sync_clk_out  <= 1'b0;
      sync_clk_oe_n <= 1'b1;
    end else begin
      pready        <= psel && !penable;
      pslverr       <= psel && !penable && bad_addr;
      prdata        <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      irq           <= |(irq_stat_reg & irq_mask_reg);
      sync_clk_out  <= sclk_reg;
      sync_clk_oe_n <= !(mode_reg.sync && mode_reg.master);
    end
  end

endmodule

//--- verilog/serial_rx_cfg.svh
`ifndef SERIAL_RX_CFG_SVH
`define SERIAL_RX_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADDR_RX_STATUS_CONTROL 12'h000
`define ADDR_RX_DATA           12'h004
`define ADDR_MODE              12'h008
`define ADDR_BAUD_DIV          12'h00c
`define ADDR_IRQ_STATUS        12'h010
`define ADDR_IRQ_MASK          12'h014

// ----------------------------------------------------------------------------
// Fields of receive_status_control
// ----------------------------------------------------------------------------
`define BIT_NINE_SEL   6
`define BIT_SINGLE_EN  5
`define BIT_CONT_EN    4
`define BIT_FRAME_ERR  2
`define BIT_OVERRUN    1
`define BIT_NINTH      0

// ----------------------------------------------------------------------------
// Fields of the mode register and interrupt registers
// ----------------------------------------------------------------------------
`define BIT_MODE_SYNC   0
`define BIT_MODE_MASTER 1
`define IRQ_RX_DONE     0
`define IRQ_FRAME       1
`define IRQ_OVERRUN     2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_STATUS_CONTROL 8'h00
`define RST_BAUD_DIV       16'h000a
`define RST_IRQ_MASK       3'h0

`endif

//--- verilog/serial_rx_pkg.sv
package serial_rx_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_STOP  = 3'b011
  } rx_state_t;

  typedef struct packed {
    logic       nine_sel;
    logic       single_en;
    logic       cont_en;
    logic       frame_err;
    logic       overrun;
    logic       ninth;
  } rx_ctrl_t;

  typedef struct packed {
    logic       sync;
    logic       master;
  } rx_mode_t;

endpackage
